// >>> logic/ncd_pkg.sv
// package: shared types and constants for the nibble data execution unit
package ncd_pkg;

   // ==========================================================
   // widths
   // ==========================================================
   localparam int NIB_W      = 4;
   localparam int X_W        = 2;
   localparam int Y_W        = 4;
   localparam int D_W        = 3;
   localparam int E_W        = 8;
   localparam int LSEL_W     = 2;
   localparam int ROM_W      = 9;
   localparam int ROM_AW     = 11;
   localparam int RAM_AW     = X_W + Y_W;
   localparam int RAM_DEPTH  = 64;

   // ==========================================================
   // field positions of a rom word
   // ==========================================================
   localparam int ROM_CY_BIT = 8;
   localparam int ROM_B_HI   = 7;
   localparam int ROM_B_LO   = 4;
   localparam int ROM_A_HI   = 3;
   localparam int ROM_A_LO   = 0;

   // ==========================================================
   // reset values and skip thresholds
   // ==========================================================
   localparam logic [3:0] NIB_RST    = 4'h0;
   localparam logic [1:0] X_RST      = 2'h0;
   localparam logic       CY_RST     = 1'b0;
   localparam logic [3:0] Y_WRAP_DEC = 4'hf;
   localparam logic [3:0] Y_WRAP_INC = 4'h0;

   // ==========================================================
   // logic selection codes
   // ==========================================================
   localparam logic [1:0] LSEL_XOR = 2'h0;
   localparam logic [1:0] LSEL_OR  = 2'h1;
   localparam logic [1:0] LSEL_AND = 2'h2;

   // ==========================================================
   // timing: table read occupies three instruction cycles
   // ==========================================================
   localparam int TBL_CYCLES = 3;

   typedef enum logic [4:0] {
      OP_NOP                 = 5'h00,
      OP_DEC_COL_PTR_SKIP    = 5'h01,
      OP_INC_COL_PTR_SKIP    = 5'h02,
      OP_LOAD_ACC_FROM_RAM   = 5'h03,
      OP_SWAP_ACC_RAM        = 5'h04,
      OP_SWAP_ACC_RAM_DEC    = 5'h05,
      OP_SWAP_ACC_RAM_INC    = 5'h06,
      OP_LOAD_POINTER_PAIR   = 5'h07,
      OP_LOAD_ACC_IMMEDIATE  = 5'h08,
      OP_ROM_TABLE_READ      = 5'h09,
      OP_ADD_RAM             = 5'h0a,
      OP_ADD_RAM_CARRY       = 5'h0b,
      OP_ADD_IMMEDIATE       = 5'h0c,
      OP_SET_CARRY           = 5'h0d,
      OP_CLEAR_CARRY         = 5'h0e,
      OP_SKIP_IF_CARRY_ZERO  = 5'h0f,
      OP_COMPLEMENT_ACC      = 5'h10,
      OP_ROTATE_RIGHT_CARRY  = 5'h11,
      OP_LOGIC_OP_EXEC       = 5'h12,
      OP_SET_RAM_BIT         = 5'h13,
      OP_CLEAR_RAM_BIT       = 5'h14,
      OP_SKIP_IF_BIT_ZERO    = 5'h15,
      OP_SKIP_IF_ACC_EQ_RAM  = 5'h16,
      OP_SKIP_IF_ACC_EQ_IMM  = 5'h17
   } ncd_op_e;

   // hi: x / j field, imm: n, y or page
   typedef struct packed {
      ncd_op_e    op;
      logic [1:0] hi;
      logic [3:0] imm;
   } ncd_instr_s;

   typedef enum logic [1:0] {
      TS_IDLE  = 2'b00,
      TS_FETCH = 2'b01,
      TS_POP   = 2'b10
   } ncd_tbl_e;

endpackage : ncd_pkg

// >>> logic/ncd_ram.sv
// file: 64 x 4 data memory in flip-flops, combinational read
`timescale 1ns/1ps
module ncd_ram #(
   parameter int DEPTH = ncd_pkg::RAM_DEPTH,
   parameter int AW    = ncd_pkg::RAM_AW,
   parameter int DW    = ncd_pkg::NIB_W
) (
   input  wire logic          mclk_i,
   input  wire logic          srst_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic          we_i,
   input  wire logic [DW-1:0] wdata_i,
   output logic      [DW-1:0] rdata_o
);

   logic [DW-1:0] mem_q [DEPTH];

   // cleared on reset so the exec unit never reads unknowns
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else if (we_i) begin
         mem_q[addr_i] <= wdata_i;
      end
   end

   assign rdata_o = mem_q[addr_i];

endmodule : ncd_ram

// >>> logic/ncd_data_ops.sv
// file: data-path execution unit of a 4-bit core (ram, arithmetic, bits)
`timescale 1ns/1ps
module ncd_data_ops #(
   parameter int TBL_CYCLES = ncd_pkg::TBL_CYCLES
) (
   input  wire logic                          mclk_i,
   input  wire logic                          srst_i,
   input  wire logic                          instr_valid_i,
   input  wire ncd_pkg::ncd_instr_s           instr_i,
   output logic                               ready_o,
   input  wire logic [ncd_pkg::E_W-1:0]       e_reg_i,
   input  wire logic [ncd_pkg::D_W-1:0]       d_reg_i,
   input  wire logic [ncd_pkg::LSEL_W-1:0]    logic_select_reg_i,
   input  wire logic                          upper_rom_bit_enable_i,
   output logic [ncd_pkg::ROM_AW-1:0]         rom_addr_o,
   output logic                               rom_rd_o,
   input  wire logic [ncd_pkg::ROM_W-1:0]     rom_data_i,
   output logic                               stk_push_o,
   output logic                               stk_pop_o,
   output logic [ncd_pkg::NIB_W-1:0]          acc_o,
   output logic [ncd_pkg::NIB_W-1:0]          b_reg_o,
   output logic                               carry_flag_o,
   output logic [ncd_pkg::X_W-1:0]            x_ptr_o,
   output logic [ncd_pkg::Y_W-1:0]            y_ptr_o,
   output logic                               skip_pending_o,
   output logic                               squashed_o
);

   // ==========================================================
   // helpers
   // ==========================================================
   // 5-bit sum so carry-out sits in bit 4
   function automatic logic [4:0] add4(input logic [3:0] a,
                                       input logic [3:0] b,
                                       input logic       ci);
      add4 = {1'b0, a} + {1'b0, b} + {4'h0, ci};
   endfunction : add4

   function automatic logic [3:0] bit_mask(input logic [1:0] j);
      bit_mask = 4'h1 << j;
   endfunction : bit_mask

   // ==========================================================
   // state
   // ==========================================================
   logic [3:0]                   acc_q, acc_d;
   logic [3:0]                   b_q, b_d;
   logic                         cy_q, cy_d;
   logic [1:0]                   x_q, x_d;
   logic [3:0]                   y_q, y_d;
   logic                         skip_q, skip_d;
   logic                         run_la_q, run_lxy_q;
   logic                         sq_q;
   ncd_pkg::ncd_tbl_e            ts_q;
   logic [ncd_pkg::ROM_AW-1:0]   rom_addr_q;
   logic                         ram_we;
   logic [3:0]                   ram_wd;
   logic [3:0]                   ram_rd;
   logic                         take;
   logic                         squash;
   logic                         is_la;
   logic                         is_lxy;
   logic [4:0]                   sum;
   logic [3:0]                   lres;

   assign ready_o = (ts_q == ncd_pkg::TS_IDLE);
   assign take    = instr_valid_i && ready_o;
   assign is_la   = (instr_i.op == ncd_pkg::OP_LOAD_ACC_IMMEDIATE);
   assign is_lxy  = (instr_i.op == ncd_pkg::OP_LOAD_POINTER_PAIR);

   assign squash = skip_q || (is_la && run_la_q) || (is_lxy && run_lxy_q);

   // ==========================================================
   // data memory, addressed by x:y
   // ==========================================================
   ncd_ram ncd_ram_i (
      .mclk_i  (mclk_i),
      .srst_i  (srst_i),
      .addr_i  ({x_q, y_q}),
      .we_i    (ram_we),
      .wdata_i (ram_wd),
      .rdata_o (ram_rd)
   );

   // ==========================================================
   // execute
   // ==========================================================
   always_comb begin
      acc_d  = acc_q;
      b_d    = b_q;
      cy_d   = cy_q;
      x_d    = x_q;
      y_d    = y_q;
      skip_d = skip_q;
      ram_we = 1'b0;
      ram_wd = ram_rd;
      sum    = 5'h00;
      lres   = acc_q ^ e_reg_i[3:0];
      if (take) begin
         skip_d = 1'b0;
         if (!squash) begin
            unique case (instr_i.op)
               ncd_pkg::OP_NOP: begin
               end
               ncd_pkg::OP_DEC_COL_PTR_SKIP: begin
                  y_d    = y_q - 4'h1;
                  skip_d = (y_d == ncd_pkg::Y_WRAP_DEC);
               end
               ncd_pkg::OP_INC_COL_PTR_SKIP: begin
                  y_d    = y_q + 4'h1;
                  skip_d = (y_d == ncd_pkg::Y_WRAP_INC);
               end
               ncd_pkg::OP_LOAD_ACC_FROM_RAM: begin
                  acc_d = ram_rd;
                  x_d   = x_q ^ instr_i.hi;
               end
               ncd_pkg::OP_SWAP_ACC_RAM: begin
                  acc_d  = ram_rd;
                  ram_we = 1'b1;
                  ram_wd = acc_q;
                  x_d    = x_q ^ instr_i.hi;
               end
               ncd_pkg::OP_SWAP_ACC_RAM_DEC: begin
                  acc_d  = ram_rd;
                  ram_we = 1'b1;
                  ram_wd = acc_q;
                  x_d    = x_q ^ instr_i.hi;
                  y_d    = y_q - 4'h1;
                  skip_d = (y_d == ncd_pkg::Y_WRAP_DEC);
               end
               ncd_pkg::OP_SWAP_ACC_RAM_INC: begin
                  acc_d  = ram_rd;
                  ram_we = 1'b1;
                  ram_wd = acc_q;
                  x_d    = x_q ^ instr_i.hi;
                  y_d    = y_q + 4'h1;
                  skip_d = (y_d == ncd_pkg::Y_WRAP_INC);
               end
               ncd_pkg::OP_LOAD_POINTER_PAIR: begin
                  x_d = instr_i.hi;
                  y_d = instr_i.imm;
               end
               ncd_pkg::OP_LOAD_ACC_IMMEDIATE: begin
                  acc_d = instr_i.imm;
               end
               // results land in the pop cycle below
               ncd_pkg::OP_ROM_TABLE_READ: begin
               end
               ncd_pkg::OP_ADD_RAM: begin
                  sum   = add4(acc_q, ram_rd, 1'b0);
                  acc_d = sum[3:0];
               end
               ncd_pkg::OP_ADD_RAM_CARRY: begin
                  sum   = add4(acc_q, ram_rd, cy_q);
                  acc_d = sum[3:0];
                  cy_d  = sum[4];
               end
               // skip when bit 3 gives no carry
               ncd_pkg::OP_ADD_IMMEDIATE: begin
                  sum    = add4(acc_q, instr_i.imm, 1'b0);
                  acc_d  = sum[3:0];
                  skip_d = !sum[4];
               end
               ncd_pkg::OP_SET_CARRY: begin
                  cy_d = 1'b1;
               end
               ncd_pkg::OP_CLEAR_CARRY: begin
                  cy_d = 1'b0;
               end
               ncd_pkg::OP_SKIP_IF_CARRY_ZERO: begin
                  skip_d = !cy_q;
               end
               ncd_pkg::OP_COMPLEMENT_ACC: begin
                  acc_d = ~acc_q;
               end
               ncd_pkg::OP_ROTATE_RIGHT_CARRY: begin
                  acc_d = {cy_q, acc_q[3:1]};
                  cy_d  = acc_q[0];
               end
               ncd_pkg::OP_LOGIC_OP_EXEC: begin
                  unique case (logic_select_reg_i)
                     ncd_pkg::LSEL_OR:  lres = acc_q | e_reg_i[3:0];
                     ncd_pkg::LSEL_AND: lres = acc_q & e_reg_i[3:0];
                     // code 3 is undefined; behaves as xor
                     default:           lres = acc_q ^ e_reg_i[3:0];
                  endcase
                  acc_d = lres;
               end
               ncd_pkg::OP_SET_RAM_BIT: begin
                  ram_we = 1'b1;
                  ram_wd = ram_rd | bit_mask(instr_i.hi);
               end
               ncd_pkg::OP_CLEAR_RAM_BIT: begin
                  ram_we = 1'b1;
                  ram_wd = ram_rd & ~bit_mask(instr_i.hi);
               end
               ncd_pkg::OP_SKIP_IF_BIT_ZERO: begin
                  skip_d = ((ram_rd & bit_mask(instr_i.hi)) == 4'h0);
               end
               ncd_pkg::OP_SKIP_IF_ACC_EQ_RAM: begin
                  skip_d = (acc_q == ram_rd);
               end
               ncd_pkg::OP_SKIP_IF_ACC_EQ_IMM: begin
                  skip_d = (acc_q == instr_i.imm);
               end
               default: begin
               end
            endcase
         end
      end else if (ts_q == ncd_pkg::TS_POP) begin
         // table word split into b, acc and optional carry
         b_d   = rom_data_i[ncd_pkg::ROM_B_HI:ncd_pkg::ROM_B_LO];
         acc_d = rom_data_i[ncd_pkg::ROM_A_HI:ncd_pkg::ROM_A_LO];
         if (upper_rom_bit_enable_i) begin
            cy_d = rom_data_i[ncd_pkg::ROM_CY_BIT];
         end
      end
   end

   // ==========================================================
   // architectural registers
   // ==========================================================
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         acc_q  <= ncd_pkg::NIB_RST;
         b_q    <= ncd_pkg::NIB_RST;
         cy_q   <= ncd_pkg::CY_RST;
         x_q    <= ncd_pkg::X_RST;
         y_q    <= ncd_pkg::NIB_RST;
         skip_q <= 1'b0;
      end else begin
         acc_q  <= acc_d;
         b_q    <= b_d;
         cy_q   <= cy_d;
         x_q    <= x_d;
         y_q    <= y_d;
         skip_q <= skip_d;
      end
   end

   // ==========================================================
   // run tracking for repeated immediate loads
   // ==========================================================
   // a run continues through its own squashed members, so only
   // the first unskipped one of any length of back-to-back loads takes effect
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         run_la_q  <= 1'b0;
         run_lxy_q <= 1'b0;
         sq_q      <= 1'b0;
      end else if (take) begin
         run_la_q  <= is_la && (run_la_q || !skip_q);
         run_lxy_q <= is_lxy && (run_lxy_q || !skip_q);
         sq_q      <= squash;
      end else begin
         sq_q      <= 1'b0;
      end
   end

   // ==========================================================
   // table read sequencer
   // ==========================================================
   // one cycle for the address, one for push and rom, one for pop;
   // the caller's stack must keep a free level for the push
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ts_q       <= ncd_pkg::TS_IDLE;
         rom_addr_q <= '0;
      end else begin
         unique case (ts_q)
            ncd_pkg::TS_IDLE: begin
               if (take && !squash &&
                   instr_i.op == ncd_pkg::OP_ROM_TABLE_READ) begin
                  ts_q       <= ncd_pkg::TS_FETCH;
                  rom_addr_q <= {instr_i.imm, d_reg_i, acc_q};
               end
            end
            // push and jump done, now pop
            ncd_pkg::TS_FETCH: ts_q <= ncd_pkg::TS_POP;
            ncd_pkg::TS_POP:   ts_q <= ncd_pkg::TS_IDLE;
            default:           ts_q <= ncd_pkg::TS_IDLE;
         endcase
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   // push with the fetch, pop with the restore
   assign stk_push_o     = (ts_q == ncd_pkg::TS_FETCH);
   assign rom_rd_o       = (ts_q == ncd_pkg::TS_FETCH);
   assign stk_pop_o      = (ts_q == ncd_pkg::TS_POP);
   assign rom_addr_o     = rom_addr_q;
   assign acc_o          = acc_q;
   assign b_reg_o        = b_q;
   assign carry_flag_o   = cy_q;
   assign x_ptr_o        = x_q;
   assign y_ptr_o        = y_q;
   assign skip_pending_o = skip_q;
   assign squashed_o     = sq_q;

endmodule : ncd_data_ops

// >>> bench/ncd_data_ops_props.sv
// checker: port-level properties of the data execution unit
`timescale 1ns/1ps
module ncd_data_ops_props #(
   parameter int TBL_CYCLES = ncd_pkg::TBL_CYCLES
) (
   input wire logic                        mclk_i,
   input wire logic                        srst_i,
   input wire logic                        instr_valid_i,
   input wire ncd_pkg::ncd_instr_s         instr_i,
   input wire logic                        ready_o,
   input wire logic [ncd_pkg::D_W-1:0]     d_reg_i,
   input wire logic [ncd_pkg::ROM_AW-1:0]  rom_addr_o,
   input wire logic                        rom_rd_o,
   input wire logic                        stk_push_o,
   input wire logic                        stk_pop_o,
   input wire logic [ncd_pkg::NIB_W-1:0]   acc_o,
   input wire logic                        carry_flag_o,
   input wire logic [ncd_pkg::Y_W-1:0]     y_ptr_o,
   input wire logic                        skip_pending_o,
   input wire logic                        squashed_o
);
   // ==========================================================
   // helpers
   // ==========================================================
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   logic            tk;
   logic            ex;
   ncd_pkg::ncd_op_e op;
   assign tk = instr_valid_i && ready_o;
   // skipped instructions must not trigger the per-opcode checks
   assign ex = tk && !skip_pending_o;
   assign op = instr_i.op;

   // ==========================================================
   // properties
   // ==========================================================
   a_tbl_walk: assert property (
      ex && op == ncd_pkg::OP_ROM_TABLE_READ |=> rom_rd_o && stk_push_o
      && !ready_o ##1 stk_pop_o && !ready_o ##1 ready_o)
      else $error("table read handshake wrong");
   a_tbl_addr: assert property (
      ex && op == ncd_pkg::OP_ROM_TABLE_READ |=> rom_addr_o ==
      {$past(instr_i.imm), $past(d_reg_i), $past(acc_o)})
      else $error("table address wrong");
   a_carry_force: assert property (
      ex && (op == ncd_pkg::OP_SET_CARRY || op == ncd_pkg::OP_CLEAR_CARRY)
      |=> carry_flag_o == ($past(op) == ncd_pkg::OP_SET_CARRY))
      else $error("carry force wrong");
   a_carry_test: assert property (
      ex && op == ncd_pkg::OP_SKIP_IF_CARRY_ZERO
      |=> skip_pending_o == !carry_flag_o && $stable(carry_flag_o))
      else $error("carry test wrong");
   a_cmpl_acc: assert property (
      ex && op == ncd_pkg::OP_COMPLEMENT_ACC |=> acc_o == ~$past(acc_o))
      else $error("complement wrong");
   a_rotate_ring: assert property (
      ex && op == ncd_pkg::OP_ROTATE_RIGHT_CARRY |=> {acc_o, carry_flag_o}
      == {$past(carry_flag_o), $past(acc_o)})
      else $error("rotate wrong");
   a_add_imm: assert property (
      ex && op == ncd_pkg::OP_ADD_IMMEDIATE |=> $stable(carry_flag_o)
      && acc_o == 4'($past(acc_o) + $past(instr_i.imm)) && skip_pending_o
      == ((5'($past(acc_o)) + 5'($past(instr_i.imm))) < 5'h10))
      else $error("add immediate wrong");
   a_dec_col: assert property (
      ex && op == ncd_pkg::OP_DEC_COL_PTR_SKIP |=> y_ptr_o ==
      4'($past(y_ptr_o) - 4'h1) && skip_pending_o == (y_ptr_o == 4'hf))
      else $error("column decrement wrong");
   a_inc_col: assert property (
      ex && op == ncd_pkg::OP_INC_COL_PTR_SKIP |=> y_ptr_o ==
      4'($past(y_ptr_o) + 4'h1) && skip_pending_o == (y_ptr_o == 4'h0))
      else $error("column increment wrong");
   a_skip_squash: assert property (
      tk && skip_pending_o |=> squashed_o && !skip_pending_o
      && $stable(acc_o) && $stable(carry_flag_o) && $stable(y_ptr_o))
      else $error("skipped instruction had effect");

   c_tbl: cover property (ex && op == ncd_pkg::OP_ROM_TABLE_READ);
   c_squash: cover property (tk && skip_pending_o);
   c_addi: cover property (ex && op == ncd_pkg::OP_ADD_IMMEDIATE);
endmodule : ncd_data_ops_props

bind ncd_data_ops ncd_data_ops_props #(.TBL_CYCLES(TBL_CYCLES)) props_i (
   .mclk_i(mclk_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i),
   .instr_i(instr_i), .ready_o(ready_o), .d_reg_i(d_reg_i),
   .rom_addr_o(rom_addr_o), .rom_rd_o(rom_rd_o), .stk_push_o(stk_push_o),
   .stk_pop_o(stk_pop_o), .acc_o(acc_o), .carry_flag_o(carry_flag_o),
   .y_ptr_o(y_ptr_o), .skip_pending_o(skip_pending_o),
   .squashed_o(squashed_o));

// >>> bench/ncd_data_ops_tb.sv
// testbench: random instruction stream checked against a reference model
`timescale 1ns/1ps
module ncd_data_ops_tb;
   // ==========================================================
   // signals
   // ==========================================================
   logic               mclk_i = 1'b0;
   logic               srst_i = 1'b1;
   logic               instr_valid_i = 1'b0;
   ncd_pkg::ncd_instr_s instr_i = '0;
   logic [7:0]         e_reg_i = 8'h00;
   logic [2:0]         d_reg_i = 3'h0;
   logic [1:0]         lsel_i = 2'h0;
   logic               urb_i = 1'b0;
   logic [8:0]         rom_data_i = 9'h000;
   logic               ready_o, rom_rd_o, stk_push_o, stk_pop_o;
   logic               carry_flag_o, skip_pending_o, squashed_o;
   logic [10:0]        rom_addr_o;
   logic [3:0]         acc_o, b_reg_o, y_ptr_o;
   logic [1:0]         x_ptr_o;
   logic [3:0]         m_acc = 4'h0, m_b = 4'h0, m_y = 4'h0;
   logic [1:0]         m_x = 2'h0;
   logic               m_cy = 1'b0, m_skip = 1'b0;
   logic [3:0]         mem [64] = '{default: 4'h0};
   ncd_pkg::ncd_op_e   lastk = ncd_pkg::OP_NOP;
   logic [9:0]         exq [$];
   int                 miscompares = 0, num_checks = 0;
   int                 n_took = 0, n_done = 0, cyc = 0;

   ncd_data_ops ncd_data_ops_i (.mclk_i(mclk_i), .srst_i(srst_i),
      .instr_valid_i(instr_valid_i), .instr_i(instr_i), .ready_o(ready_o),
      .e_reg_i(e_reg_i), .d_reg_i(d_reg_i), .logic_select_reg_i(lsel_i),
      .upper_rom_bit_enable_i(urb_i), .rom_addr_o(rom_addr_o),
      .rom_rd_o(rom_rd_o), .rom_data_i(rom_data_i),
      .stk_push_o(stk_push_o), .stk_pop_o(stk_pop_o), .acc_o(acc_o),
      .b_reg_o(b_reg_o), .carry_flag_o(carry_flag_o), .x_ptr_o(x_ptr_o),
      .y_ptr_o(y_ptr_o), .skip_pending_o(skip_pending_o),
      .squashed_o(squashed_o));

   initial begin
      forever #12.5 mclk_i = ~mclk_i;
   end

   // ==========================================================
   // checking
   // ==========================================================
   task automatic cmp_state(input logic [9:0] e, s);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("FAIL state exp %h seen %h", e, s);
      end
   endtask : cmp_state

   task automatic cmp_ptr(input logic [9:0] e, s);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("FAIL pointers exp %h seen %h", e, s);
      end
   endtask : cmp_ptr

   task automatic give_verdict();
      // a stalled unit leaves notes behind that were never compared
      if (exq.size() != 0) begin
         miscompares++;
         $display("FAIL queue exp 0 seen %0d", exq.size());
      end
      if (miscompares == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict

   always @(posedge mclk_i) begin
      cyc++;
      if (instr_valid_i && ready_o && !srst_i) n_took++;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end

   // a table read shows its result only once ready returns
   always @(negedge mclk_i) begin
      if (n_done < n_took && ready_o) begin
         n_done++;
         cmp_state(exq.pop_front(), {acc_o, b_reg_o, carry_flag_o,
            squashed_o});
         cmp_ptr(exq.pop_front(), {4'h0, x_ptr_o,
            y_ptr_o});
      end
   end

   // ==========================================================
   // reference model and driver
   // ==========================================================
   task automatic exec(input ncd_pkg::ncd_instr_s i);
      logic [3:0] m, dy, ev;
      logic [4:0] s;
      logic [1:0] lv;
      logic [8:0] rw;
      logic       sq;
      ev = 4'($urandom);
      lv = 2'($urandom);
      rw = 9'($urandom);
      m = mem[{m_x, m_y}];
      dy = 4'h0;
      sq = m_skip || (i.op == lastk && (i.op == ncd_pkg::OP_LOAD_POINTER_PAIR
         || i.op == ncd_pkg::OP_LOAD_ACC_IMMEDIATE));
      lastk = m_skip ? ncd_pkg::OP_NOP : i.op;
      m_skip = 1'b0;
      if (!sq) case (i.op)
         ncd_pkg::OP_DEC_COL_PTR_SKIP: dy = 4'hf;
         ncd_pkg::OP_INC_COL_PTR_SKIP: dy = 4'h1;
         ncd_pkg::OP_LOAD_ACC_FROM_RAM, ncd_pkg::OP_SWAP_ACC_RAM,
         ncd_pkg::OP_SWAP_ACC_RAM_DEC, ncd_pkg::OP_SWAP_ACC_RAM_INC: begin
            if (i.op != ncd_pkg::OP_LOAD_ACC_FROM_RAM) mem[{m_x, m_y}] = m_acc;
            m_acc = m;
            m_x = m_x ^ i.hi;
            if (i.op == ncd_pkg::OP_SWAP_ACC_RAM_DEC) dy = 4'hf;
            if (i.op == ncd_pkg::OP_SWAP_ACC_RAM_INC) dy = 4'h1;
         end
         ncd_pkg::OP_LOAD_POINTER_PAIR: {m_x, m_y} = {i.hi, i.imm};
         ncd_pkg::OP_LOAD_ACC_IMMEDIATE: m_acc = i.imm;
         ncd_pkg::OP_ROM_TABLE_READ: begin
            {m_b, m_acc} = rw[7:0];
            if (lv[0]) m_cy = rw[8];
         end
         ncd_pkg::OP_ADD_RAM: m_acc = m_acc + m;
         ncd_pkg::OP_ADD_RAM_CARRY: {m_cy, m_acc} = m_acc + m + m_cy;
         ncd_pkg::OP_ADD_IMMEDIATE: begin
            s = m_acc + i.imm;
            m_acc = s[3:0];
            m_skip = !s[4];
         end
         ncd_pkg::OP_SET_CARRY: m_cy = 1'b1;
         ncd_pkg::OP_CLEAR_CARRY: m_cy = 1'b0;
         ncd_pkg::OP_SKIP_IF_CARRY_ZERO: m_skip = !m_cy;
         ncd_pkg::OP_COMPLEMENT_ACC: m_acc = ~m_acc;
         ncd_pkg::OP_ROTATE_RIGHT_CARRY: {m_acc, m_cy} = {m_cy, m_acc};
         ncd_pkg::OP_LOGIC_OP_EXEC: m_acc = lv == 2'h1 ? m_acc | ev :
            lv == 2'h2 ? m_acc & ev : m_acc ^ ev;
         ncd_pkg::OP_SET_RAM_BIT: mem[{m_x, m_y}][i.hi] = 1'b1;
         ncd_pkg::OP_CLEAR_RAM_BIT: mem[{m_x, m_y}][i.hi] = 1'b0;
         ncd_pkg::OP_SKIP_IF_BIT_ZERO: m_skip = !m[i.hi];
         ncd_pkg::OP_SKIP_IF_ACC_EQ_RAM: m_skip = (m_acc == m);
         ncd_pkg::OP_SKIP_IF_ACC_EQ_IMM: m_skip = (m_acc == i.imm);
         default: ;
      endcase
      if (dy != 4'h0) begin
         m_y = m_y + dy;
         m_skip = (m_y == (dy == 4'hf ? 4'hf : 4'h0));
      end
      exq.push_back({m_acc, m_b, m_cy, sq});
      exq.push_back({4'h0, m_x, m_y});
      // hold inputs through a table read: rom word sampled two cycles on
      if (instr_i.op == ncd_pkg::OP_ROM_TABLE_READ) begin
         repeat (2) @(posedge mclk_i);
      end
      instr_valid_i <= 1'b1;
      instr_i <= i;
      e_reg_i <= {4'($urandom), ev};
      d_reg_i <= 3'($urandom);
      lsel_i <= lv;
      urb_i <= lv[0];
      rom_data_i <= rw;
      @(posedge mclk_i);
   endtask : exec

   initial begin
      ncd_pkg::ncd_instr_s n;
      void'($urandom(96));
      repeat (4) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(posedge mclk_i);
      for (int k = 0; k < 800; k++) begin
         n.op = ncd_pkg::ncd_op_e'(5'($urandom % 23) + 5'h1);
         // repeats give back-to-back load runs
         if ($urandom % 4 == 0) n.op = instr_i.op;
         n.hi = 2'($urandom);
         n.imm = 4'($urandom);
         if (n.op == ncd_pkg::OP_ROM_TABLE_READ && m_skip) begin
            n.op = ncd_pkg::OP_NOP;
         end
         exec(n);
      end
      instr_valid_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      give_verdict();
   end
endmodule : ncd_data_ops_tb
